// ===== hw/vpo_pkg.sv
// Behaviour
// - Red, green and blue each leave on their own 10-bit bus, one word per pixel.
// - A pixel clock accompanies the colour words, with a complementary copy.
// - Framed line sync leaves aligned with the pixel words it delimits.
// - Framed line sync carries horizontal pulses only, composite content removed.
// - Buffered line sync repeats the selected sync source unchanged.
// - Composite mode: buffered frame sync asserted while the line pattern is disrupted.
// - Mode changes and command completion are signalled on the open-drain alert.
// - Active video flag high during active samples, low in all blanking.
// - Field flag toggles between interlaced fields with line sync selected (composite modes hold the first field); its high sense is configurable.
package vpo_pkg;
   localparam int WORD_W     = 10;
   localparam int POS_W      = 12;
   localparam int FIFO_DEPTH = 2;

   // Sync source selection codes
   localparam logic [1:0] SEL_LINE  = 2'h0;
   localparam logic [1:0] SEL_GREEN = 2'h1;
   localparam logic [1:0] SEL_COMP  = 2'h2;

   // Missed lines counted before the next line without an on-time sync edge makes the line period be learnt again
   localparam logic [2:0] RELEARN_LINES = 3'h7;

   localparam logic [POS_W-1:0] POS_ONE = 12'h001;
   localparam logic [POS_W-1:0] POS_MAX = 12'hfff;

   typedef struct packed {
      logic [WORD_W-1:0] red;
      logic [WORD_W-1:0] green;
      logic [WORD_W-1:0] blue;
   } vpo_pixel_type;

   typedef struct packed {
      vpo_pixel_type pix;
      logic          active;
      logic          line_sync;
      logic          green_sync;
      logic          comp_sync;
      logic          frame_sync;
   } vpo_src_type;

   typedef struct packed {
      vpo_pixel_type pix;
      logic          active;
      logic          hsync;
      logic          field;
   } vpo_entry_type;

   typedef enum logic [1:0] {
      LEARN_IDLE,
      LEARN_MEASURE,
      LEARN_LOCKED
   } vpo_learn_type;
endpackage : vpo_pkg

// ===== hw/vpo_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
module vpo_fifo2
   import vpo_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          resetn,
   // Fill side
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire vpo_entry_type in_data,
   // Drain side
   output logic               out_valid,
   input  wire logic          out_ready,
   output vpo_entry_type      out_data
);
   vpo_entry_type mem [FIFO_DEPTH];
   logic          wr_ptr;
   logic          rd_ptr;
   logic [1:0]    count;
   wire           push = in_valid && in_ready;
   wire           pop  = out_valid && out_ready;

   assign in_ready  = (count != 2'(FIFO_DEPTH));
   assign out_valid = (count != 2'h0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem[i] <= '0;
         end
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   chk_fifo_count_step: assert property (@(posedge clk_sys) disable iff (!resetn)
      push && !pop |=> count == $past(count) + 2'h1)
      else $error("fifo count did not grow on push");

   chk_fifo_full_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
      !in_ready && !out_ready |=> !in_ready && out_data == $past(out_data))
      else $error("full fifo lost or changed its head word");
endmodule : vpo_fifo2
`default_nettype wire

// ===== hw/vpo_pixel_port.sv
`timescale 1ns/1ps
`default_nettype none
module vpo_pixel_port
   import vpo_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   // Source side, pixel clock domain
   input  wire logic              pixel_clock_in,
   input  wire vpo_src_type       src,
   output logic                   src_ready,
   // Configuration
   input  wire logic [1:0]        sync_select,
   input  wire logic              field_polarity,
   // Receiver side
   input  wire logic              out_ready,
   output logic                   pixel_clock_out,
   output logic                   pixel_clock_out_n,
   output logic [WORD_W-1:0]      red_out,
   output logic [WORD_W-1:0]      green_out,
   output logic [WORD_W-1:0]      blue_out,
   output logic                   active_video_flag,
   output logic                   framed_line_sync_out,
   output logic                   field_flag,
   // Measurement copies
   output logic                   buffered_line_sync_out,
   output logic                   buffered_frame_sync_out,
   // Host alert, open drain
   input  wire logic              mode_change_pulse,
   input  wire logic              cmd_done_pulse,
   input  wire logic              alert_ack,
   input  wire logic              alert_in,
   output logic                   alert_out,
   output logic                   alert_oe
);
   // Pixel clock synchroniser; only the second stage reads the first
   logic clk_s1;
   logic clk_s2;
   logic clk_s3;
   logic clk_lvl;
   wire  clk_change = (clk_s2 == clk_s3) && (clk_s2 != clk_lvl);
   wire  pix_rise   = clk_change && clk_s2;
   wire  pix_fall   = clk_change && !clk_s2;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         clk_s1  <= 1'b0;
         clk_s2  <= 1'b0;
         clk_s3  <= 1'b0;
         clk_lvl <= 1'b0;
      end else begin
         clk_s1 <= pixel_clock_in;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         if (clk_change) begin
            clk_lvl <= clk_s2;
         end
      end
   end

   // The source bundle is read only on a confirmed rising edge; it is held
   // for the whole pixel period, so a few cycles of lag is safe.
   wire composite = (sync_select != SEL_LINE);
   wire sel_sync  = (sync_select == SEL_LINE)  ? src.line_sync  :
                    (sync_select == SEL_GREEN) ? src.green_sync : src.comp_sync;

   logic              sync_prev;
   wire               lead = sel_sync && !sync_prev;
   wire               trail = !sel_sync && sync_prev;

   // Line flywheel: pos counts pixels from the last accepted sync edge
   vpo_learn_type     learn;
   logic [POS_W-1:0]  pos;
   logic [POS_W-1:0]  line_len;
   logic [POS_W-1:0]  sync_len;
   logic [2:0]        miss_cnt;
   logic              odd_edge;
   logic              disrupt;
   logic              frame_prev;
   logic              field_state;
   logic              mode_evt;

   wire               locked   = (learn == LEARN_LOCKED);
   wire               at_wrap  = locked && (pos == line_len - POS_ONE);
   wire               on_time  = lead && at_wrap;
   wire               learnt   = (learn == LEARN_MEASURE) && lead;
   wire [POS_W-1:0]   next_pos = (at_wrap || learnt || (lead && learn == LEARN_IDLE)) ?
                                 '0 : pos + POS_ONE;
   wire               frame_src  = composite ? disrupt : src.frame_sync;
   wire               frame_lead = frame_src && !frame_prev;
   wire               framed_h = locked ? (next_pos < sync_len) : (!composite && sel_sync);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         learn    <= LEARN_IDLE;
         pos      <= '0;
         line_len <= '0;
         sync_len <= '0;
         miss_cnt <= 3'h0;
         odd_edge <= 1'b0;
         disrupt  <= 1'b0;
         mode_evt <= 1'b0;
      end else begin
         mode_evt <= 1'b0;
         if (pix_rise) begin
            pos <= next_pos;
            case (learn)
               LEARN_IDLE: begin
                  if (lead) begin
                     learn <= LEARN_MEASURE;
                  end
               end
               LEARN_MEASURE: begin
                  if (lead) begin
                     learn    <= LEARN_LOCKED;
                     line_len <= pos + POS_ONE;
                     miss_cnt <= 3'h0;
                     mode_evt <= (pos + POS_ONE != line_len);
                  end else if (pos == POS_MAX) begin
                     learn <= LEARN_IDLE;
                  end
               end
               LEARN_LOCKED: begin
                  // serrations and equalisation do not restart the line
                  if (lead && !at_wrap) begin
                     odd_edge <= 1'b1;
                  end
                  if (trail && !odd_edge && !disrupt) begin
                     sync_len <= next_pos;
                  end
                  if (at_wrap) begin
                     disrupt  <= odd_edge || !on_time;
                     odd_edge <= 1'b0;
                     miss_cnt <= on_time ? 3'h0 : miss_cnt + 3'h1;
                     if (!on_time && miss_cnt == RELEARN_LINES) begin
                        learn    <= LEARN_IDLE;
                        mode_evt <= 1'b1;
                     end
                  end
               end
               default: begin
                  learn <= LEARN_IDLE;
               end
            endcase
         end
      end
   end

   // Field, sync edge memory and measurement copies, all on the pixel rate
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync_prev               <= 1'b0;
         frame_prev              <= 1'b0;
         field_state             <= 1'b0;
         buffered_line_sync_out  <= 1'b0;
         buffered_frame_sync_out <= 1'b0;
      end else if (pix_rise) begin
         sync_prev  <= sel_sync;
         frame_prev <= frame_src;
         // frame start in mid line marks the other field
         if (frame_lead) begin
            field_state <= (pos >= (line_len >> 1));
         end
         // selected source passed through as is
         buffered_line_sync_out  <= sel_sync;
         buffered_frame_sync_out <= frame_src;
      end
   end

   // Two-entry buffer between the capture edge and the launch edge
   vpo_entry_type push_word;
   vpo_entry_type head_word;
   logic          head_valid;
   wire           pop_now = pix_fall && head_valid && out_ready;

   always_comb begin
      push_word.pix    = src.pix;
      push_word.active = src.active && !framed_h && !frame_src;
      push_word.hsync  = framed_h;
      push_word.field  = field_state ^ field_polarity;
   end

   vpo_fifo2 u_buf (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .in_valid  (pix_rise),
      .in_ready  (src_ready),
      .in_data   (push_word),
      .out_valid (head_valid),
      .out_ready (pix_fall && out_ready),
      .out_data  (head_word)
   );

   // Launch on the falling edge of pixel_clock_out so the receiver samples
   // mid-word on the rising edge. A stall repeats the word as blanking.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pixel_clock_out      <= 1'b0;
         pixel_clock_out_n    <= 1'b1;
         red_out              <= '0;
         green_out            <= '0;
         blue_out             <= '0;
         active_video_flag    <= 1'b0;
         framed_line_sync_out <= 1'b0;
         field_flag           <= 1'b0;
      end else begin
         if (pix_rise) begin
            pixel_clock_out   <= 1'b1;
            pixel_clock_out_n <= 1'b0;
         end else if (pix_fall) begin
            pixel_clock_out   <= 1'b0;
            pixel_clock_out_n <= 1'b1;
         end
         // one launch edge for every pixel-aligned output
         if (pop_now) begin
            red_out              <= head_word.pix.red;
            green_out            <= head_word.pix.green;
            blue_out             <= head_word.pix.blue;
            active_video_flag    <= head_word.active;
            framed_line_sync_out <= head_word.hsync;
            field_flag           <= head_word.field;
         end else if (pix_fall) begin
            active_video_flag <= 1'b0;
         end
      end
   end

   // Alert: event sets win over a same-cycle acknowledge
   logic alert_pending;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         alert_pending <= 1'b0;
      end else begin
         alert_pending <= (alert_pending && !alert_ack) ||
                          mode_change_pulse || cmd_done_pulse || mode_evt;
      end
   end
   // drive low only, line floats high otherwise
   assign alert_out = 1'b0;
   assign alert_oe  = alert_pending;

   chk_clk_complement: assert property (@(posedge clk_sys) disable iff (!resetn)
      pixel_clock_out_n == !pixel_clock_out)
      else $error("pixel clock complement broken");

   chk_clk_follows_rise: assert property (@(posedge clk_sys) disable iff (!resetn)
      pix_rise |=> pixel_clock_out ##1 pixel_clock_out)
      else $error("pixel clock not high after input rise");

   chk_words_on_launch: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(red_out) || $changed(blue_out) |-> $past(pop_now) && !pixel_clock_out)
      else $error("colour word moved outside a launch");

   chk_coherent_update: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(framed_line_sync_out) || $changed(field_flag) |-> $past(pop_now))
      else $error("sync or field moved apart from the word");

   chk_blank_in_sync: assert property (@(posedge clk_sys) disable iff (!resetn)
      pop_now && head_word.hsync |=> framed_line_sync_out && !active_video_flag)
      else $error("active flag high during line sync");

   chk_serr_no_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
      pix_rise && locked && lead && !at_wrap |=> pos == $past(pos) + POS_ONE)
      else $error("off-time sync edge restarted the line");

   chk_frame_disrupt: assert property (@(posedge clk_sys) disable iff (!resetn)
      pix_rise && locked && at_wrap && odd_edge |=> disrupt)
      else $error("disrupted line not flagged");

   chk_frame_copy: assert property (@(posedge clk_sys) disable iff (!resetn)
      pix_rise && composite |=> buffered_frame_sync_out == $past(disrupt))
      else $error("frame copy differs from disruption flag");

   chk_line_copy: assert property (@(posedge clk_sys) disable iff (!resetn)
      pix_rise |=> buffered_line_sync_out == $past(sel_sync))
      else $error("line sync copy differs from selected source");

   chk_alert_set_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
      mode_change_pulse || cmd_done_pulse |=> alert_oe && !alert_out)
      else $error("alert not pulled low after event");

   chk_alert_release: assert property (@(posedge clk_sys) disable iff (!resetn)
      alert_ack && !mode_change_pulse && !cmd_done_pulse && !mode_evt |=> !alert_oe)
      else $error("alert held after acknowledge");

   chk_field_sense: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(field_polarity) && !$past(pix_rise) |-> push_word.field != $past(push_word.field))
      else $error("field sense ignores polarity setting");
endmodule : vpo_pixel_port
`default_nettype wire

// ===== tb/vpo_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module vpo_rx_model
   import vpo_pkg::*;
(
   // Clock and bench control
   input  wire logic          clk_sys,
   input  wire logic          resetn,
   input  wire logic          clr,
   input  wire logic          stall,
   // Port outputs seen by the receiver
   input  wire logic          pclk,
   input  wire vpo_pixel_type pix,
   input  wire logic          act,
   input  wire logic          hs,
   input  wire logic          fld,
   input  wire logic          bls,
   input  wire logic          bfs,
   input  wire logic          alert_oe,
   input  wire logic          alert_out,
   // Receiver answers and tallies
   output logic               out_ready,
   output logic               alert_wire,
   output var int             n_act,
   output var int             n_hs,
   output var int             n_bls,
   output logic               seen_bfs,
   output logic               last_fld,
   output logic               order_ok
);
   logic              pclk_d;
   logic              bls_d;
   logic [WORD_W-1:0] prev_red;

   // host pull-up on the alert line
   assign alert_wire = alert_oe ? alert_out : 1'b1;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         out_ready <= 1'b1;
         pclk_d    <= 1'b0;
         bls_d     <= 1'b0;
      end else begin
         out_ready <= !stall;
         pclk_d    <= pclk;
         bls_d     <= bls;
         if (clr) begin
            n_act    <= 0;
            n_hs     <= 0;
            n_bls    <= 0;
            seen_bfs <= 1'b0;
            order_ok <= 1'b1;
            prev_red <= '0;
         end else begin
            if (bls && !bls_d) n_bls <= n_bls + 1;
            if (bfs) seen_bfs <= 1'b1;
            // sample the pixel-aligned outputs on the pixel clock rise
            if (pclk && !pclk_d) begin
               last_fld <= fld;
               if (hs) n_hs <= n_hs + 1;
               if (act) begin
                  n_act    <= n_act + 1;
                  prev_red <= pix.red;
                  // three channels of one pixel arrive together
                  if (pix.green !== ~pix.red || pix.blue !== (pix.red ^ 10'h155)
                      || pix.red <= prev_red) order_ok <= 1'b0;
               end
            end
         end
      end
   end
endmodule : vpo_rx_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import vpo_pkg::*;
;
   logic              clk_sys = 1'b0, resetn = 1'b0, pixel_clock_in = 1'b0;
   vpo_src_type       src = '0;
   logic [1:0]        sync_select = 2'h0;
   logic              field_polarity = 1'b0, mode_change_pulse = 1'b0;
   logic              cmd_done_pulse = 1'b0, alert_ack = 1'b0, stall = 1'b0, clr = 1'b0;
   logic              out_ready, src_ready, pixel_clock_out, pixel_clock_out_n;
   logic [WORD_W-1:0] red_out, green_out, blue_out;
   logic              active_video_flag, framed_line_sync_out, field_flag;
   logic              buffered_line_sync_out, buffered_frame_sync_out, alert_out, alert_oe;
   logic              alert_wire, seen_bfs, last_fld, order_ok, prev_pco = 1'b0;
   logic              ready_low = 1'b0;
   logic [32:0]       prev_out = '0;
   int                n_act, n_hs, n_bls, errors = 0, check_count = 0, k = 1;

   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   vpo_pixel_port uut (.clk_sys(clk_sys), .resetn(resetn), .pixel_clock_in(pixel_clock_in),
      .src(src), .src_ready(src_ready), .sync_select(sync_select),
      .field_polarity(field_polarity), .out_ready(out_ready),
      .pixel_clock_out(pixel_clock_out), .pixel_clock_out_n(pixel_clock_out_n),
      .red_out(red_out), .green_out(green_out), .blue_out(blue_out),
      .active_video_flag(active_video_flag), .framed_line_sync_out(framed_line_sync_out),
      .field_flag(field_flag), .buffered_line_sync_out(buffered_line_sync_out),
      .buffered_frame_sync_out(buffered_frame_sync_out),
      .mode_change_pulse(mode_change_pulse), .cmd_done_pulse(cmd_done_pulse),
      .alert_ack(alert_ack), .alert_in(alert_wire), .alert_out(alert_out),
      .alert_oe(alert_oe));

   vpo_rx_model rx (.clk_sys(clk_sys), .resetn(resetn), .clr(clr), .stall(stall),
      .pclk(pixel_clock_out), .pix({red_out, green_out, blue_out}),
      .act(active_video_flag), .hs(framed_line_sync_out), .fld(field_flag),
      .bls(buffered_line_sync_out), .bfs(buffered_frame_sync_out), .alert_oe(alert_oe),
      .alert_out(alert_out), .out_ready(out_ready), .alert_wire(alert_wire),
      .n_act(n_act), .n_hs(n_hs), .n_bls(n_bls), .seen_bfs(seen_bfs),
      .last_fld(last_fld), .order_ok(order_ok));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test;
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test

   always @(negedge clk_sys) begin
      if (resetn) begin
         check("clock complement", pixel_clock_out_n, !pixel_clock_out);
         if ({red_out, green_out, blue_out, active_video_flag, framed_line_sync_out,
              field_flag} !== prev_out)
            check("update edge", {prev_pco, pixel_clock_out}, 2'b10);
         if (src_ready === 1'b0) ready_low = 1'b1;
      end
      prev_out = {red_out, green_out, blue_out, active_video_flag, framed_line_sync_out,
                  field_flag};
      prev_pco = pixel_clock_out;
   end

   // One pixel period is 32 system clocks, 160 ns
   task automatic pixel(input vpo_src_type s, input logic st);
      @(posedge clk_sys);
      pixel_clock_in <= 1'b1;
      src            <= s;
      stall          <= st;
      repeat (16) @(posedge clk_sys);
      pixel_clock_in <= 1'b0;
      repeat (15) @(posedge clk_sys);
   endtask : pixel

   // Sixteen pixels: sync 0..1, optional serration 8..9, active 4..13
   task automatic line(input logic [1:0] sel, input logic serr, input int frame_at,
                       input logic st);
      vpo_src_type s;
      logic        sy;
      for (int p = 0; p < 16; p++) begin
         sy           = (p < 2) || (serr && p >= 8 && p < 10);
         s            = '0;
         s.active     = (p >= 4 && p < 14);
         s.line_sync  = sy && sel == 2'h0;
         s.green_sync = sy && sel == 2'h1;
         s.comp_sync  = sy && sel[1];
         s.frame_sync = frame_at >= 0 && p >= frame_at;
         if (s.active) begin
            s.pix = {k[9:0], ~k[9:0], k[9:0] ^ 10'h155};
            k++;
         end
         pixel(s, st && p >= 6 && p < 10);
      end
   endtask : line

   task automatic clear;
      @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
   endtask : clear

   task automatic t_reset;
      check("reset outputs", {pixel_clock_out, pixel_clock_out_n, active_video_flag,
            alert_oe, src_ready, alert_wire}, 6'h13);
   endtask : t_reset

   task automatic t_alert;
      @(posedge clk_sys) cmd_done_pulse <= 1'b1;
      @(posedge clk_sys) cmd_done_pulse <= 1'b0;
      @(negedge clk_sys) check("alert set", {alert_oe, alert_wire}, 2'b10);
      repeat (5) @(negedge clk_sys);
      check("alert held", alert_oe, 1'b1);
      @(posedge clk_sys) mode_change_pulse <= 1'b1;
      alert_ack <= 1'b1;
      @(posedge clk_sys) mode_change_pulse <= 1'b0;
      alert_ack <= 1'b0;
      @(negedge clk_sys) check("set over clear", alert_oe, 1'b1);
      @(posedge clk_sys) alert_ack <= 1'b1;
      @(posedge clk_sys) alert_ack <= 1'b0;
      @(negedge clk_sys) check("alert clear", {alert_oe, alert_wire}, 2'b01);
   endtask : t_alert

   // Four stalled launches drop three pushes once the buffer is full
   task automatic t_stream;
      clear();
      line(2'h0, 1'b0, -1, 1'b0);
      line(2'h0, 1'b0, -1, 1'b1);
      line(2'h0, 1'b0, -1, 1'b0);
      check("active words", n_act, 27);
      check("word order", order_ok, 1'b1);
      check("buffer full", ready_low, 1'b1);
      check("mode alert", alert_oe, 1'b1);
   endtask : t_stream

   task automatic t_sync;
      for (int sel = 0; sel < 3; sel++) begin
         sync_select <= sel[1:0];
         line(sel[1:0], 1'b0, -1, 1'b0);
         clear();
         line(sel[1:0], 1'b0, -1, 1'b0);
         line(sel[1:0], 1'b1, -1, 1'b0);
         line(sel[1:0], 1'b1, -1, 1'b0);
         line(sel[1:0], 1'b0, -1, 1'b0);
         check("framed sync words", n_hs, 8);
         check("buffered sync pulses", n_bls, 6);
         check("frame sync seen", seen_bfs, sel != 0);
         line(sel[1:0], 1'b0, -1, 1'b0);
         line(sel[1:0], 1'b0, -1, 1'b0);
         check("frame sync idle", buffered_frame_sync_out, 1'b0);
      end
   endtask : t_sync

   task automatic t_field;
      sync_select <= 2'h0;
      for (int pol = 0; pol < 2; pol++) begin
         field_polarity <= pol[0];
         line(2'h0, 1'b0, 2, 1'b0);
         line(2'h0, 1'b0, -1, 1'b0);
         check("first field", last_fld, pol[0]);
         line(2'h0, 1'b0, 10, 1'b0);
         line(2'h0, 1'b0, -1, 1'b0);
         check("second field", last_fld, !pol[0]);
      end
   endtask : t_field

   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      @(negedge clk_sys);
      t_reset();
      t_alert();
      t_stream();
      t_sync();
      t_field();
      finish_test();
   end

   // About 32 lines of 2.56 us each are expected; allow about 2.4 times that
   initial begin
      #200000;
      errors++;
      finish_test();
   end
endmodule : tb
`default_nettype wire
